// ===== ocarb_top.sv
// Object control arbiter: source selection, mode gating and pulse timing
`timescale 1ns/1ns

module ocarb_top #(
  parameter int TICK_CYCLES = ocarb_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ocarb_pkg::NUM_DI-1:0] binary_input_line,
  input wire logic function_key_a,
  input wire logic function_key_b,
  input wire logic [ocarb_pkg::NUM_OBJ-1:0] obj_open_ind,
  input wire logic [ocarb_pkg::NUM_OBJ-1:0] obj_close_ind,
  input wire logic panel_local_sel,
  input wire logic mode_from_di,
  input wire logic [2:0] mode_di_sel,
  input wire logic [ocarb_pkg::NUM_CTRL-1:0] panel_open_cmd,
  input wire logic [ocarb_pkg::NUM_CTRL-1:0] panel_close_cmd,
  input wire logic [ocarb_pkg::NUM_CTRL-1:0] serial_open_cmd,
  input wire logic [ocarb_pkg::NUM_CTRL-1:0] serial_close_cmd,
  input wire ocarb_pkg::ocarb_src_cfg_t [ocarb_pkg::NUM_CTRL-1:0] src_cfg,
  input wire logic [ocarb_pkg::NUM_CTRL-1:0][15:0] max_pulse_ticks,
  input wire logic [1:0] key_object_control_select,
  input wire logic [1:0][2:0] key_toggle_target,
  output logic local_control_active,
  output logic [ocarb_pkg::NUM_CTRL-1:0] open_pulse,
  output logic [ocarb_pkg::NUM_CTRL-1:0] close_pulse,
  output logic [ocarb_pkg::NUM_OBJ-1:0][1:0] obj_state,
  output logic [ocarb_pkg::NUM_CTRL-1:0] obj_failed,
  output logic [ocarb_pkg::NUM_CTRL-1:0] undefined_event,
  output logic [ocarb_pkg::NUM_VI-1:0] virtual_input_lines,
  output logic [1:0] function_button_state,
  output ocarb_pkg::ocarb_key_rpt_t [1:0] key_link_report
);

  localparam int NC = ocarb_pkg::NUM_CTRL;
  localparam int NO = ocarb_pkg::NUM_OBJ;
  localparam int ND = ocarb_pkg::NUM_DI;
  localparam int SYW = 2 * NO + 2 + ND;  // All pins that need a synchroniser

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYW-1:0] sy1_r;  // First stage, read by sy2_r only
  logic [SYW-1:0] sy2_r;  // Second stage, safe to use
  logic [ND-1:0] di_s;
  logic [1:0] key_s;
  logic [NO-1:0] ind_open_s;
  logic [NO-1:0] ind_close_s;

  // Two flops per pin, no reset needed on the data path
  always_ff @(posedge clk) begin
    sy1_r <= {obj_close_ind, obj_open_ind, function_key_b, function_key_a, binary_input_line};
    sy2_r <= sy1_r;
  end
  assign {ind_close_s, ind_open_s, key_s, di_s} = sy2_r;

  // ****************************************
  // State registers and next values
  // ****************************************
  logic local_r, local_nxt;                    // Local control state
  logic [1:0] key_prev_r;                      // Key levels of last cycle
  logic [NC-1:0][3:0] sel_prev_r, sel_prev_nxt;  // Selected levels of last cycle
  logic [ocarb_pkg::NUM_VI-1:0] vi_r, vi_nxt;  // Virtual input lines
  logic [1:0] fb_r, fb_nxt;                    // Function button states
  logic [31:0] tick_cnt_r, tick_cnt_nxt;       // 10 ms divider
  logic tick_r, tick_nxt;                      // One-cycle tick enable
  ocarb_pkg::ocarb_obj_st_t st_r [NC];         // Per-object control state
  ocarb_pkg::ocarb_obj_st_t st_nxt [NC];
  logic [NC-1:0][15:0] tmr_r, tmr_nxt;         // Elapsed ticks of a pulse
  logic [NC-1:0] open_r, open_nxt, close_r, close_nxt;
  logic [NC-1:0] fail_r, fail_nxt, evt_r, evt_nxt;
  logic [NO-1:0][1:0] ost_r, ost_nxt;          // Encoded object states
  ocarb_pkg::ocarb_key_rpt_t [1:0] rpt_r, rpt_nxt;

  // ****************************************
  // Request sources and gating
  // ****************************************
  logic [1:0] key_edge;
  logic [15:0] src_lvl;  // Level of every selectable source
  logic [NC-1:0][3:0] sel_lvl, sel_edge;
  logic [NC-1:0] open_req, close_req;

  assign key_edge = key_s & ~key_prev_r;
  // A key in object-control mode becomes a selectable local source
  assign src_lvl = {1'b0, key_s[1] & key_object_control_select[1],
                    key_s[0] & key_object_control_select[0], vi_r, di_s, 1'b0};

  // Pick the four selected levels and catch their rising edges
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      sel_lvl[i] = {src_lvl[src_cfg[i].rem_open], src_lvl[src_cfg[i].rem_close],
                    src_lvl[src_cfg[i].loc_open], src_lvl[src_cfg[i].loc_close]};
      sel_edge[i] = sel_lvl[i] & ~sel_prev_r[i];
      sel_prev_nxt[i] = sel_lvl[i];
      // No password term anywhere: serial commands go straight
      open_req[i] = local_r ? (sel_edge[i][1] | panel_open_cmd[i])
                            : (sel_edge[i][3] | serial_open_cmd[i]);
      close_req[i] = local_r ? (sel_edge[i][0] | panel_close_cmd[i])
                             : (sel_edge[i][2] | serial_close_cmd[i]);
    end
  end

  // ****************************************
  // Mode, keys, divider, state encoding
  // ****************************************
  // Mode select; a binary input is the usual station-wide switch
  always_comb begin
    local_nxt = mode_from_di ? di_s[mode_di_sel] : panel_local_sel;
    vi_nxt = vi_r;
    fb_nxt = fb_r;
    for (int k = 0; k < 2; k++) begin
      if (key_edge[k] && key_object_control_select[k] == ocarb_pkg::KEY_MODE_TOGGLE) begin
        if (key_toggle_target[k] < ocarb_pkg::TGT_FB0) begin
          vi_nxt[key_toggle_target[k][1:0]] = ~vi_nxt[key_toggle_target[k][1:0]];
        end else begin
          fb_nxt[key_toggle_target[k][0]] = ~fb_nxt[key_toggle_target[k][0]];
        end
      end
    end
    tick_nxt = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick_nxt ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    for (int j = 0; j < NO; j++) begin
      ost_nxt[j] = {ind_close_s[j], ind_open_s[j]};
    end
  end

  // Key link report; a count above one means the key is shared
  always_comb begin
    logic [3:0] cnt;
    logic [3:0] code;
    cnt = 4'h0;
    code = 4'h0;
    rpt_nxt = '0;
    for (int k = 0; k < 2; k++) begin
      cnt = 4'h0;
      code = (k == 0) ? ocarb_pkg::SRC_KEY_A : ocarb_pkg::SRC_KEY_B;
      rpt_nxt[k] = '0;
      for (int i = 0; i < NC; i++) begin
        if (src_cfg[i].loc_open == code) begin
          cnt = cnt + 4'h1;
          rpt_nxt[k].obj = 3'(i);
          rpt_nxt[k].is_close = 1'b0;
        end
        if (src_cfg[i].loc_close == code) begin
          cnt = cnt + 4'h1;
          rpt_nxt[k].obj = 3'(i);
          rpt_nxt[k].is_close = 1'b1;
        end
      end
      rpt_nxt[k].code = (cnt == 4'h0) ? ocarb_pkg::RPT_NONE :
                        (cnt == 4'h1) ? ocarb_pkg::RPT_ONE : ocarb_pkg::RPT_MANY;
    end
  end

  // ****************************************
  // Per-object pulse control
  // ****************************************
  // Only the commandable objects get a machine; the rest just report
  always_comb begin
    logic [15:0] lim;
    logic reached;
    lim = 16'h0000;
    reached = 1'b0;
    evt_nxt = '0;
    for (int i = 0; i < NC; i++) begin
      st_nxt[i] = st_r[i];
      tmr_nxt[i] = tmr_r[i];
      fail_nxt[i] = fail_r[i];
      // Settings below the least length would make a useless pulse
      lim = (max_pulse_ticks[i] < ocarb_pkg::PULSE_MIN_TICKS) ?
            ocarb_pkg::PULSE_MIN_TICKS : max_pulse_ticks[i];
      case (st_r[i])
        ocarb_pkg::OBJ_IDLE: begin
          // Both at once is ambiguous, so neither is obeyed
          if (open_req[i] && !close_req[i]) begin
            st_nxt[i] = ocarb_pkg::OBJ_OPENING;
            tmr_nxt[i] = 16'h0000;
          end else if (close_req[i] && !open_req[i]) begin
            st_nxt[i] = ocarb_pkg::OBJ_CLOSING;
            tmr_nxt[i] = 16'h0000;
          end
        end
        ocarb_pkg::OBJ_OPENING, ocarb_pkg::OBJ_CLOSING: begin
          reached = (st_r[i] == ocarb_pkg::OBJ_OPENING) ? (ost_r[i] == ocarb_pkg::ST_OPEN)
                                                        : (ost_r[i] == ocarb_pkg::ST_CLOSED);
          if (reached) begin
            st_nxt[i] = ocarb_pkg::OBJ_IDLE;
            fail_nxt[i] = 1'b0;
          end else if (tick_r) begin
            if (tmr_r[i] + 16'h0001 >= lim) begin
              st_nxt[i] = ocarb_pkg::OBJ_IDLE;
              fail_nxt[i] = 1'b1;
              evt_nxt[i] = 1'b1;
            end else begin
              tmr_nxt[i] = tmr_r[i] + 16'h0001;
            end
          end
        end
        default: begin
          st_nxt[i] = ocarb_pkg::OBJ_IDLE;
        end
      endcase
      open_nxt[i] = (st_nxt[i] == ocarb_pkg::OBJ_OPENING);
      close_nxt[i] = (st_nxt[i] == ocarb_pkg::OBJ_CLOSING);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Synchronous reset; edge history starts low so a held input fires once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      local_r <= 1'b0;
      key_prev_r <= 2'h0;
      sel_prev_r <= '0;
      vi_r <= '0;
      fb_r <= 2'h0;
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
      tmr_r <= '0;
      open_r <= '0;
      close_r <= '0;
      fail_r <= '0;
      evt_r <= '0;
      ost_r <= '0;
      rpt_r <= '0;
      for (int i = 0; i < NC; i++) begin
        st_r[i] <= ocarb_pkg::OBJ_IDLE;
      end
    end else begin
      local_r <= local_nxt;
      key_prev_r <= key_s;
      sel_prev_r <= sel_prev_nxt;
      vi_r <= vi_nxt;
      fb_r <= fb_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      tmr_r <= tmr_nxt;
      open_r <= open_nxt;
      close_r <= close_nxt;
      fail_r <= fail_nxt;
      evt_r <= evt_nxt;
      ost_r <= ost_nxt;
      rpt_r <= rpt_nxt;
      for (int i = 0; i < NC; i++) begin
        st_r[i] <= st_nxt[i];
      end
    end
  end

  // Outputs straight from flops
  assign local_control_active = local_r;
  assign open_pulse = open_r;
  assign close_pulse = close_r;
  assign obj_state = ost_r;
  assign obj_failed = fail_r;
  assign undefined_event = evt_r;
  assign virtual_input_lines = vi_r;
  assign function_button_state = fb_r;
  assign key_link_report = rpt_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < NC; g++) begin : g_chk
    property p_rem_ignored;
      local_r && !sel_edge[g][1] && !panel_open_cmd[g] |-> !open_req[g];
    endproperty
    a_rem_ignored: assert property (p_rem_ignored) else $error("remote open taken in local");
    property p_serial_rejected;
      local_r && serial_close_cmd[g] && !sel_edge[g][0] && !panel_close_cmd[g] |-> !close_req[g];
    endproperty
    a_serial_rejected: assert property (p_serial_rejected) else $error("serial taken in local");
    property p_panel_rejected;
      !local_r && panel_open_cmd[g] && !sel_edge[g][3] && !serial_open_cmd[g] |-> !open_req[g];
    endproperty
    a_panel_rejected: assert property (p_panel_rejected) else $error("panel taken in remote");
    property p_start_cause;
      $rose(open_r[g]) |-> $past(open_req[g] && !close_req[g]);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("open pulse without request");
    property p_both_rejected;
      st_r[g] == ocarb_pkg::OBJ_IDLE && open_req[g] && close_req[g] |=> !open_r[g] && !close_r[g];
    endproperty
    a_both_rejected: assert property (p_both_rejected) else $error("pulse on double request");
    property p_fail_event;
      $rose(fail_r[g]) |-> evt_r[g] && $fell(open_r[g] | close_r[g]) ##1 !evt_r[g];
    endproperty
    a_fail_event: assert property (p_fail_event) else $error("failure without event");
    property p_stop_reached;
      open_r[g] && ost_r[g] == ocarb_pkg::ST_OPEN |=> !open_r[g] && !fail_r[g];
    endproperty
    a_stop_reached: assert property (p_stop_reached) else $error("pulse held past open");
  end

  property p_mode_di;
    mode_from_di |=> local_r == $past(di_s[mode_di_sel]);
  endproperty
  a_mode_di: assert property (p_mode_di) else $error("mode not from binary input");
  // Key b kept quiet so only key a can flip a virtual input
  property p_key_toggle;
    key_edge[0] && key_object_control_select[0] == ocarb_pkg::KEY_MODE_TOGGLE &&
      key_toggle_target[0] < ocarb_pkg::TGT_FB0 &&
      !(key_edge[1] && key_object_control_select[1] == ocarb_pkg::KEY_MODE_TOGGLE)
      |=> (vi_r ^ $past(vi_r)) == (4'h1 << $past(key_toggle_target[0][1:0]));
  endproperty
  a_key_toggle: assert property (p_key_toggle) else $error("key did not toggle");

  // Helper: objects whose local controls name key a
  logic [NC-1:0] uses_key_a;
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      uses_key_a[i] = (src_cfg[i].loc_open == ocarb_pkg::SRC_KEY_A) ||
                      (src_cfg[i].loc_close == ocarb_pkg::SRC_KEY_A);
    end
  end
  property p_key_none;
    uses_key_a == '0 |=> rpt_r[0].code == ocarb_pkg::RPT_NONE;
  endproperty
  a_key_none: assert property (p_key_none) else $error("unused key not shown as dash");
  property p_key_many;
    src_cfg[0].loc_open == ocarb_pkg::SRC_KEY_A && src_cfg[1].loc_close == ocarb_pkg::SRC_KEY_A
      |=> rpt_r[0].code == ocarb_pkg::RPT_MANY;
  endproperty
  a_key_many: assert property (p_key_many) else $error("shared key not reported");

  c_open_done: cover property (open_r[0] ##1 !open_r[0] && !fail_r[0]);
  c_timeout: cover property ($rose(evt_r[1]));
  c_key_obj: cover property (key_edge[0] && key_object_control_select[0] ##1 open_r[0]);
  c_remote: cover property (!local_r && serial_open_cmd[0] ##1 open_r[0]);

endmodule

// ===== ocarb_pkg.sv
// Constants and carrier types of the object control arbiter
package ocarb_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_OBJ = 8;   // Objects with a state indication
  localparam int NUM_CTRL = 6;  // Objects that may be commanded
  localparam int NUM_DI = 8;    // Binary input lines
  localparam int NUM_VI = 4;    // Virtual input lines
  localparam int SRC_W = 4;     // Width of a request source selector
  localparam int TMR_W = 16;    // Width of a pulse length in ticks

  // ****************************************
  // Request source codes
  // ****************************************
  localparam logic [3:0] SRC_NONE = 4'h0;   // No input selected
  localparam logic [3:0] SRC_DI0 = 4'h1;    // First binary input line
  localparam logic [3:0] SRC_VI0 = 4'h9;    // First virtual input line
  localparam logic [3:0] SRC_KEY_A = 4'hD;  // Function key a as object control
  localparam logic [3:0] SRC_KEY_B = 4'hE;  // Function key b as object control

  // ****************************************
  // Object state codes, {close_ind, open_ind}
  // ****************************************
  localparam logic [1:0] ST_UNDEF_00 = 2'h0;
  localparam logic [1:0] ST_OPEN = 2'h1;
  localparam logic [1:0] ST_CLOSED = 2'h2;
  localparam logic [1:0] ST_UNDEF_11 = 2'h3;

  // ****************************************
  // Function key settings and report codes
  // ****************************************
  localparam logic KEY_MODE_TOGGLE = 1'b0;  // Key toggles its target
  localparam logic KEY_MODE_OBJ = 1'b1;     // Key acts as object control
  localparam logic [2:0] TGT_FB0 = 3'h4;    // Targets 0..3 virtual inputs, 4..5 buttons
  localparam logic [1:0] RPT_NONE = 2'h0;   // Shown as a dash
  localparam logic [1:0] RPT_ONE = 2'h1;    // One linked control
  localparam logic [1:0] RPT_MANY = 2'h2;   // Shown as a question mark

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_MS = 10;  // Pulse length resolution
  localparam int TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [15:0] PULSE_MIN_TICKS = 16'h0002;  // 0.02 s
  localparam logic [15:0] PULSE_MAX_TICKS = 16'hEA60;  // 600 s
  localparam int REQ_MIN_MS = 60;  // Least request pulse from a source

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [3:0] rem_open;
    logic [3:0] rem_close;
    logic [3:0] loc_open;
    logic [3:0] loc_close;
  } ocarb_src_cfg_t;

  typedef struct packed {
    logic [1:0] code;   // RPT_NONE, RPT_ONE or RPT_MANY
    logic [2:0] obj;    // Linked object, zero based
    logic is_close;     // Linked control is a close
  } ocarb_key_rpt_t;

  typedef enum {OBJ_IDLE, OBJ_OPENING, OBJ_CLOSING} ocarb_obj_st_t;

endpackage

// ===== ocarb_obj_model.sv
// Switchgear object model that answers control pulses with position indications
`timescale 1ns/1ns
module ocarb_obj_model (
  input wire logic clk,
  input wire logic [5:0] open_pulse,
  input wire logic [5:0] close_pulse,
  input wire logic [7:0] move_dly,
  input wire logic [5:0] stuck,
  input wire logic [1:0] ro_open,
  input wire logic [1:0] ro_close,
  output logic [7:0] open_ind,
  output logic [7:0] close_ind
);
  // ****************************************
  // Moving objects
  // ****************************************
  logic [5:0] o_r = 6'h00;  // Open contacts of the commandable objects
  logic [5:0] c_r = 6'h3F;  // All start closed
  int cnt [6] = '{default: 0};  // Cycles spent moving

  // Read-only objects simply mirror what the bench sets
  assign open_ind = {ro_open, o_r};
  assign close_ind = {ro_close, c_r};

  // A moving object shows neither end position until travel completes
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if ((open_pulse[i] || close_pulse[i]) && !stuck[i]) begin
        if (cnt[i] >= int'(move_dly)) begin
          // Arrived: one indication only
          {c_r[i], o_r[i]} <= {close_pulse[i], open_pulse[i]};
        end else begin
          // Travelling, position unknown
          {c_r[i], o_r[i]} <= 2'h0;
        end
        cnt[i] <= cnt[i] + 1;
      end else begin
        // Idle or jammed: stays where it is
        cnt[i] <= 0;
      end
    end
  end
endmodule

// ===== ocarb_top_bench.sv
// Self-checking bench for the object control arbiter
`timescale 1ns/1ns
module ocarb_top_bench;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  localparam int TICK_SIM = 10;  // Short tick keeps timeouts quick
  localparam int HOLD = ocarb_pkg::REQ_MIN_MS / ocarb_pkg::TICK_MS * TICK_SIM;
  localparam int CYC_LIMIT = 4000;  // Whole run needs roughly 800
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] binary_input_line = 8'h00;
  logic function_key_a = 1'b0;
  logic function_key_b = 1'b0;
  logic panel_local_sel = 1'b0;
  logic mode_from_di = 1'b0;
  logic [2:0] mode_di_sel = 3'h7;
  logic [5:0] panel_open_cmd = 6'h00;
  logic [5:0] panel_close_cmd = 6'h00;
  logic [5:0] serial_open_cmd = 6'h00;
  logic [5:0] serial_close_cmd = 6'h00;
  ocarb_pkg::ocarb_src_cfg_t [5:0] src_cfg = '0;
  logic [5:0][15:0] max_pulse_ticks = {{4{16'h000A}}, 16'h0004, 16'h000A};
  logic [1:0] key_object_control_select = 2'h3;
  logic [1:0][2:0] key_toggle_target = {3'h5, 3'h2};  // Key b to button 1, key a to VI 2
  logic [7:0] move_dly = 8'h08;
  logic [5:0] stuck = 6'h00;
  logic [1:0] ro_open = 2'h0;
  logic [1:0] ro_close = 2'h0;
  logic [7:0] obj_open_ind;
  logic [7:0] obj_close_ind;
  logic local_control_active;
  logic [5:0] open_pulse;
  logic [5:0] close_pulse;
  logic [7:0][1:0] obj_state;
  logic [5:0] obj_failed;
  logic [5:0] undefined_event;
  logic [3:0] virtual_input_lines;
  logic [1:0] function_button_state;
  ocarb_pkg::ocarb_key_rpt_t [1:0] key_link_report;
  logic [5:0] op_q = 6'h00;  // Pulse history for edge counting
  logic [5:0] cp_q = 6'h00;
  int n_open [6] = '{default: 0};
  int n_close [6] = '{default: 0};
  int n_fail = 0;
  int samples_checked = 0;
  int evt_cyc = 0;  // High cycles of the failure event on object 1
  int plen = 0;  // Length of the last open pulse on object 1
  int cycles = 0;

  always #10 clk = ~clk;

  // ****************************************
  // Design and far side
  // ****************************************
  ocarb_top #(.TICK_CYCLES(TICK_SIM)) i_ocarb_top (
    .clk(clk), .rst_n(rst_n), .binary_input_line(binary_input_line),
    .function_key_a(function_key_a), .function_key_b(function_key_b),
    .obj_open_ind(obj_open_ind), .obj_close_ind(obj_close_ind),
    .panel_local_sel(panel_local_sel), .mode_from_di(mode_from_di), .mode_di_sel(mode_di_sel),
    .panel_open_cmd(panel_open_cmd), .panel_close_cmd(panel_close_cmd),
    .serial_open_cmd(serial_open_cmd), .serial_close_cmd(serial_close_cmd),
    .src_cfg(src_cfg), .max_pulse_ticks(max_pulse_ticks),
    .key_object_control_select(key_object_control_select),
    .key_toggle_target(key_toggle_target), .local_control_active(local_control_active),
    .open_pulse(open_pulse), .close_pulse(close_pulse), .obj_state(obj_state),
    .obj_failed(obj_failed), .undefined_event(undefined_event),
    .virtual_input_lines(virtual_input_lines),
    .function_button_state(function_button_state), .key_link_report(key_link_report)
  );

  ocarb_obj_model i_ocarb_obj_model (
    .clk(clk), .open_pulse(open_pulse), .close_pulse(close_pulse), .move_dly(move_dly),
    .stuck(stuck), .ro_open(ro_open), .ro_close(ro_close),
    .open_ind(obj_open_ind), .close_ind(obj_close_ind)
  );

  // ****************************************
  // Monitor and hang guard
  // ****************************************
  // Sampled on the falling edge, where design outputs have settled
  always @(negedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (open_pulse[i] === 1'b1 && op_q[i] === 1'b0) n_open[i]++;
      if (close_pulse[i] === 1'b1 && cp_q[i] === 1'b0) n_close[i]++;
    end
    if (open_pulse[1] === 1'b1) plen = (op_q[1] === 1'b1) ? plen + 1 : 1;
    if (undefined_event[1] === 1'b1) evt_cyc++;
    op_q = open_pulse;
    cp_q = close_pulse;
    cycles++;
    if (cycles == CYC_LIMIT) begin
      n_fail++;
      $display("Error at %0t: cycle limit got %h expected %h", $time, cycles, 0);
      summarize();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait, bounded, until no control pulse is running
  task automatic settle();
    int k;
    k = 0;
    cyc(6);
    while ((open_pulse | close_pulse) !== 6'h00 && k < 400) begin
      cyc(1);
      k++;
    end
    cyc(4);
  endtask

  // Pins 0..7 are binary inputs, 8 is key a, 9 is key b
  task automatic drive(input int idx, input logic v);
    if (idx < 8) binary_input_line[idx] = v;
    else if (idx == 8) function_key_a = v;
    else function_key_b = v;
  endtask

  // Level request held for the least recommended width, then released
  task automatic hold_req(input int idx);
    drive(idx, 1'b1);
    cyc(HOLD);
    drive(idx, 1'b0);
    settle();
  endtask

  // One-cycle command: panel open, panel close, serial open, serial close
  task automatic cmd(input logic [23:0] v);
    {panel_open_cmd, panel_close_cmd, serial_open_cmd, serial_close_cmd} = v;
    cyc(1);
    {panel_open_cmd, panel_close_cmd, serial_open_cmd, serial_close_cmd} = 24'h000000;
    settle();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    // Object 0: remote by inputs 0/1, local by the two keys
    src_cfg[0] = {ocarb_pkg::SRC_DI0, ocarb_pkg::SRC_DI0 + 4'h1, ocarb_pkg::SRC_KEY_A,
                  ocarb_pkg::SRC_KEY_B};
    cyc(4);
    check({open_pulse, close_pulse, obj_failed, undefined_event}, 32'h0);
    check({key_link_report, virtual_input_lines, function_button_state, local_control_active},
          32'h0);
    cyc(1);
    rst_n = 1'b1;
    cyc(6);
    check(key_link_report, {ocarb_pkg::RPT_ONE, 3'h0, 1'b1, ocarb_pkg::RPT_ONE, 3'h0, 1'b0});
    // Mode source: a binary input, then the panel
    check(local_control_active, 32'h0);
    mode_from_di = 1'b1;
    binary_input_line[7] = 1'b1;
    cyc(6);
    check(local_control_active, 32'h1);
    binary_input_line[7] = 1'b0;
    cyc(6);
    check(local_control_active, 32'h0);
    mode_from_di = 1'b0;
    panel_local_sel = 1'b1;
    cyc(2);
    check(local_control_active, 32'h1);
    panel_local_sel = 1'b0;
    cyc(2);
    // Remote state
    check(obj_state[0], ocarb_pkg::ST_CLOSED);
    cmd(24'h040000);  // Panel open, refused
    check(n_open[0], 32'h0);
    hold_req(8);  // Local key source, refused
    check(n_open[0], 32'h0);
    cmd(24'h000040);  // Serial open, no password step
    check(n_open[0], 32'h1);
    check(obj_state[0], ocarb_pkg::ST_OPEN);
    hold_req(1);  // Held level gives a single operation
    check(n_close[0], 32'h1);
    check(obj_state[0], ocarb_pkg::ST_CLOSED);
    // Local state
    panel_local_sel = 1'b1;
    cyc(2);
    cmd(24'h000040);  // Serial open, refused
    check(n_open[0], 32'h1);
    hold_req(0);  // Remote pin source, refused
    check(n_open[0], 32'h1);
    move_dly = 8'h14;  // Slow mechanism
    cmd(24'h040000);
    check(n_open[0], 32'h2);
    move_dly = 8'h08;
    hold_req(9);  // Key b as local close
    check(n_close[0], 32'h2);
    hold_req(8);  // Key a as local open
    check(n_open[0], 32'h3);
    check(obj_state[0], ocarb_pkg::ST_OPEN);
    cmd(24'h041000);  // Open and close together
    check({n_open[0][15:0], n_close[0][15:0]}, 32'h00030002);
    // Jammed object 1 runs into its pulse limit
    stuck = 6'h02;
    cmd(24'h080000);
    check({obj_failed[1], 7'h0, evt_cyc[7:0]}, 32'h8001);
    check(32'((plen >= 3 * TICK_SIM) && (plen <= 4 * TICK_SIM + 2)), 32'h1);
    stuck = 6'h00;
    cmd(24'h080000);
    check({obj_failed[1], obj_state[1]}, {1'b0, ocarb_pkg::ST_OPEN});
    // Keys in toggle mode leave objects alone
    key_object_control_select = 2'h0;
    hold_req(8);
    check(virtual_input_lines, 32'h4);
    hold_req(8);
    hold_req(9);
    check({virtual_input_lines, function_button_state}, 32'h02);
    check(n_close[0], 32'h2);
    // Read-only objects report every code
    for (int c = 0; c < 4; c++) begin
      {ro_close[0], ro_open[0]} = 2'(c);
      {ro_close[1], ro_open[1]} = 2'(3 - c);
      cyc(6);
      check({obj_state[7], obj_state[6]}, 32'((3 - c) * 4 + c));
    end
    // Link report with a shared key, then with none
    src_cfg[1].loc_close = ocarb_pkg::SRC_KEY_A;
    cyc(3);
    check(key_link_report[0].code, ocarb_pkg::RPT_MANY);
    src_cfg = '0;
    cyc(3);
    check({key_link_report[1].code, key_link_report[0].code}, 32'h0);
    summarize();
  end
endmodule
